// ===== src/jmic_top.sv
// jmic_top: mode selection, link parameter derivation and alignment-sequence fields behind a wishbone slave
//
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
module jmic_top (
	// clock and reset
	input  wire logic                  I_CORE_CLK,
	input  wire logic                  I_SYS_RST,
	// wishbone slave
	input  wire logic                  I_WB_CYC,
	input  wire logic                  I_WB_STB,
	input  wire logic                  I_WB_WE,
	input  wire logic [7:0]            I_WB_ADR,
	input  wire logic [3:0]            I_WB_SEL,
	input  wire logic [31:0]           I_WB_DAT,
	output logic      [31:0]           O_WB_DAT,
	output logic                       O_WB_ACK,
	// converter arrangement
	output logic                       O_INTERLEAVE,
	output logic                       O_RATE_X2,
	output logic                       O_INPUT_SEL,
	output logic                       O_DDC_EN,
	output logic      [4:0]            O_DECIMATION,
	// serializer control
	output logic                       O_LINK_RST,
	output logic                       O_SCR_EN,
	output logic      [4:0]            O_PLL_MULT_X4,
	output logic                       O_PLL_BYPASS,
	output logic      [15:0]           O_LANE_EN,
	// alignment-sequence content
	output jmic_pkg::jmic_link_s       O_ILAS_A,
	output jmic_pkg::jmic_link_s       O_ILAS_B,
	output logic      [127:0]          O_LANE_CHKSUM,
	output logic      [1:0]            O_CS_ACTUAL
);
	// all state of the block
	typedef struct packed {
		logic                 link_en;
		logic                 scr_en;
		logic                 inp_sel;
		logic [4:0]           mode;
		logic [4:0]           k_m1;
		logic [7:0]           did;
		logic                 ack;
		logic [31:0]          rdat;
		logic                 interleave;
		logic                 rate_x2;
		logic                 input_sel;
		logic                 ddc_en;
		logic [4:0]           decim;
		logic                 link_rst;
		logic                 scr_out;
		logic [4:0]           pll_mult;
		logic                 pll_byp;
		logic [15:0]          lane_en;
		jmic_pkg::jmic_link_s ilas_a;
		jmic_pkg::jmic_link_s ilas_b;
		logic [127:0]         chksum;
		logic [1:0]           cs_act;
	} jmic_state_s;

	jmic_state_s         st_ff;
	jmic_state_s         nxt_st;
	jmic_pkg::jmic_mode_s cur_md;
	jmic_pkg::jmic_mode_s wr_md;
	jmic_pkg::jmic_link_s link_a;
	jmic_pkg::jmic_link_s link_b;
	logic [127:0]        lane_sum;
	logic [15:0]         lane_on;
	logic                k_ok;
	logic                req;

	// mode lookup from the single selector drives everything below
	assign cur_md = jmic_pkg::mode_lookup(st_ff.mode);
	assign wr_md  = jmic_pkg::mode_lookup(I_WB_DAT[4:0]);
	assign k_ok   = jmic_pkg::k_legal(cur_md, st_ff.k_m1);
	assign req    = I_WB_CYC && I_WB_STB && !st_ff.ack;

	// link A fields; count fields carry value minus one
	always_comb begin
		link_a           = '0;
		link_a.did       = st_ff.did;
		link_a.l_m1      = 5'({1'b0, cur_md.l} - 5'h01);
		link_a.scr       = st_ff.scr_en;
		link_a.f_m1      = 8'({4'h0, cur_md.f} - 8'h01);
		link_a.k_m1      = st_ff.k_m1;
		link_a.m_m1      = 8'({4'h0, cur_md.m} - 8'h01);
		link_a.cs        = 2'h0;
		link_a.n_m1      = cur_md.n - 5'h01;
		link_a.subclassv = jmic_pkg::SUBCLS_VAL;
		link_a.np_m1     = cur_md.np - 5'h01;
		link_a.jesdv     = jmic_pkg::JESDV_VAL;
		link_a.s_m1      = 5'({1'b0, cur_md.s} - 5'h01);
	end

	// link B differs only in its identifier
	always_comb begin
		link_b     = link_a;
		link_b.did = st_ff.did + 8'h01;
	end

	// per-lane checksum and enable, eight lanes on each link
	genvar gi;
	generate
		for (gi = 0; gi < jmic_pkg::LANES_LINK; gi++) begin : g_lane
			jmic_lane #(
				.LANE_ID (5'(gi))
			) u_lane_a (
				.i_link       (link_a),
				.i_lanes_used (cur_md.l),
				.i_link_used  (cur_md.valid),
				.o_chksum     (lane_sum[8*gi +: 8]),
				.o_en         (lane_on[gi])
			);
			jmic_lane #(
				.LANE_ID (5'(gi))
			) u_lane_b (
				.i_link       (link_b),
				.i_lanes_used (cur_md.l),
				.i_link_used  (cur_md.valid && (cur_md.links == 2'd2)),
				.o_chksum     (lane_sum[8*(gi+jmic_pkg::LANES_LINK) +: 8]),
				.o_en         (lane_on[gi+jmic_pkg::LANES_LINK])
			);
		end
	endgenerate

	// register access and derived outputs
	always_comb begin
		nxt_st     = st_ff;
		nxt_st.ack = req;
		// write path: only byte lane 0 carries fields
		if (req && I_WB_WE && I_WB_SEL[0]) begin
			unique case (I_WB_ADR)
				jmic_pkg::ADR_CTRL: begin
					nxt_st.link_en = I_WB_DAT[jmic_pkg::CTRL_EN_BIT];
					nxt_st.scr_en  = I_WB_DAT[jmic_pkg::CTRL_SCR_BIT];
					nxt_st.inp_sel = I_WB_DAT[jmic_pkg::CTRL_INP_BIT];
				end
				jmic_pkg::ADR_MODE: begin
					if (wr_md.valid) begin
						nxt_st.mode = I_WB_DAT[4:0];
					end
				end
				jmic_pkg::ADR_K_M1: begin
					if (jmic_pkg::k_legal(cur_md, I_WB_DAT[4:0])) begin
						nxt_st.k_m1 = I_WB_DAT[4:0];
					end
				end
				jmic_pkg::ADR_DID: begin
					nxt_st.did = I_WB_DAT[7:0];
				end
				default: begin
				end
			endcase
		end
		// read path: unmapped and write cycles return zero
		nxt_st.rdat = 32'h0000_0000;
		if (req && !I_WB_WE) begin
			unique case (I_WB_ADR)
				jmic_pkg::ADR_CTRL: begin
					nxt_st.rdat[jmic_pkg::CTRL_EN_BIT]  = st_ff.link_en;
					nxt_st.rdat[jmic_pkg::CTRL_SCR_BIT] = st_ff.scr_en;
					nxt_st.rdat[jmic_pkg::CTRL_INP_BIT] = st_ff.inp_sel;
				end
				jmic_pkg::ADR_MODE: nxt_st.rdat[4:0] = st_ff.mode;
				jmic_pkg::ADR_K_M1: nxt_st.rdat[4:0] = st_ff.k_m1;
				jmic_pkg::ADR_DID:  nxt_st.rdat[7:0] = st_ff.did;
				jmic_pkg::ADR_STATUS: begin
					nxt_st.rdat[0]     = cur_md.des;
					nxt_st.rdat[1]     = k_ok;
					nxt_st.rdat[2]     = st_ff.ddc_en;
					nxt_st.rdat[3]     = st_ff.link_en;
					nxt_st.rdat[8:4]   = cur_md.dec;
					nxt_st.rdat[13:9]  = cur_md.rx4;
					nxt_st.rdat[15:14] = cur_md.links;
					nxt_st.rdat[19:16] = cur_md.l;
					nxt_st.rdat[21:20] = cur_md.cs;
				end
				jmic_pkg::ADR_PARAMS: begin
					nxt_st.rdat[3:0]   = cur_md.f;
					nxt_st.rdat[7:4]   = cur_md.m;
					nxt_st.rdat[12:8]  = cur_md.n;
					nxt_st.rdat[20:16] = cur_md.np;
					nxt_st.rdat[27:24] = cur_md.s;
				end
				jmic_pkg::ADR_CHKSUM: begin
					nxt_st.rdat[7:0]  = st_ff.chksum[7:0];
					nxt_st.rdat[15:8] = st_ff.chksum[71:64];
				end
				default: begin
				end
			endcase
		end
		// converter arrangement follows the mode
		nxt_st.interleave = cur_md.des;
		nxt_st.rate_x2    = cur_md.des;
		nxt_st.input_sel  = cur_md.des && st_ff.inp_sel;
		nxt_st.ddc_en     = !cur_md.des && (cur_md.dec != 5'd1);
		nxt_st.decim      = cur_md.dec;
		// serializer: link held in reset while disabled
		nxt_st.link_rst   = !st_ff.link_en;
		nxt_st.scr_out    = st_ff.scr_en;
		nxt_st.pll_mult   = cur_md.rx4;
		nxt_st.pll_byp    = (cur_md.rx4 == jmic_pkg::RX4_BYPASS);
		nxt_st.lane_en    = st_ff.link_en ? lane_on : 16'h0000;
		// alignment-sequence content for the transmitter
		nxt_st.ilas_a     = link_a;
		nxt_st.ilas_b     = link_b;
		nxt_st.chksum     = lane_sum;
		nxt_st.cs_act     = cur_md.cs;
	end

	// state register with synchronous reset
	always_ff @(posedge I_CORE_CLK) begin
		if (I_SYS_RST) begin
			st_ff          <= '0;
			st_ff.mode     <= jmic_pkg::MODE_RST;
			st_ff.k_m1     <= jmic_pkg::K_M1_RST;
			st_ff.did      <= jmic_pkg::DID_RST;
			st_ff.link_rst <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// outputs straight from the state register
	assign O_WB_DAT      = st_ff.rdat;
	assign O_WB_ACK      = st_ff.ack;
	assign O_INTERLEAVE  = st_ff.interleave;
	assign O_RATE_X2     = st_ff.rate_x2;
	assign O_INPUT_SEL   = st_ff.input_sel;
	assign O_DDC_EN      = st_ff.ddc_en;
	assign O_DECIMATION  = st_ff.decim;
	assign O_LINK_RST    = st_ff.link_rst;
	assign O_SCR_EN      = st_ff.scr_out;
	assign O_PLL_MULT_X4 = st_ff.pll_mult;
	assign O_PLL_BYPASS  = st_ff.pll_byp;
	assign O_LANE_EN     = st_ff.lane_en;
	assign O_ILAS_A      = st_ff.ilas_a;
	assign O_ILAS_B      = st_ff.ilas_b;
	assign O_LANE_CHKSUM = st_ff.chksum;
	assign O_CS_ACTUAL   = st_ff.cs_act;
endmodule

// ===== src/jmic_pkg.sv
// jmic_pkg: register map, mode table and alignment-sequence field layout for the mode/ilas configuration block
package jmic_pkg;
	// register byte offsets
	localparam logic [7:0] ADR_CTRL    = 8'h00;
	localparam logic [7:0] ADR_MODE    = 8'h04;
	localparam logic [7:0] ADR_K_M1    = 8'h08;
	localparam logic [7:0] ADR_DID     = 8'h0C;
	localparam logic [7:0] ADR_STATUS  = 8'h10;
	localparam logic [7:0] ADR_PARAMS  = 8'h14;
	localparam logic [7:0] ADR_CHKSUM  = 8'h18;
	// control register bits
	localparam int CTRL_EN_BIT  = 0;
	localparam int CTRL_SCR_BIT = 1;
	localparam int CTRL_INP_BIT = 2;
	// reset values
	localparam logic [4:0] MODE_RST = 5'h00;
	localparam logic [4:0] K_M1_RST = 5'h1F;
	localparam logic [7:0] DID_RST  = 8'h00;
	// fixed numbers
	localparam logic [5:0] K_MAX       = 6'h20;
	localparam logic [4:0] RX4_BYPASS  = 5'h04;
	localparam int         LANES_LINK  = 8;
	localparam logic [2:0] JESDV_VAL   = 3'h1;
	localparam logic [2:0] SUBCLS_VAL  = 3'h1;

	// derived parameters of one operating mode
	typedef struct packed {
		logic       valid;
		logic [5:0] kmin;
		logic       kstep2;   // K must step by two
		logic [4:0] dec;
		logic       des;
		logic [1:0] links;
		logic [4:0] n;
		logic [4:0] np;
		logic [3:0] l;
		logic [3:0] m;
		logic [3:0] f;
		logic [3:0] s;
		logic [4:0] rx4;      // bits per lane per clock, times four
		logic [1:0] cs;       // control bits actually appended
	} jmic_mode_s;

	// alignment-sequence fields common to all lanes of one link
	typedef struct packed {
		logic [7:0] did;
		logic [3:0] bid;
		logic [3:0] adjcnt;
		logic       phadj;
		logic       adjdir;
		logic [4:0] l_m1;
		logic       scr;
		logic [7:0] f_m1;
		logic [4:0] k_m1;
		logic [7:0] m_m1;
		logic [1:0] cs;
		logic [4:0] n_m1;
		logic [2:0] subclassv;
		logic [4:0] np_m1;
		logic [2:0] jesdv;
		logic [4:0] s_m1;
		logic       hd;
		logic [4:0] cf;
		logic [7:0] res1;
		logic [7:0] res2;
	} jmic_link_s;

	function automatic jmic_mode_s mk(input logic [5:0] kmin, input logic ks2, input logic [4:0] dec,
		input logic des, input logic [1:0] lk, input logic [4:0] n, input logic [4:0] np,
		input logic [3:0] l, input logic [3:0] m, input logic [3:0] f, input logic [3:0] s,
		input logic [4:0] rx4);
		jmic_mode_s r;
		r.valid  = 1'b1;
		r.kmin   = kmin;
		r.kstep2 = ks2;
		r.dec    = dec;
		r.des    = des;
		r.links  = lk;
		r.n      = n;
		r.np     = np;
		r.l      = l;
		r.m      = m;
		r.f      = f;
		r.s      = s;
		r.rx4    = rx4;
		r.cs     = (n == 5'd15) ? 2'h1 : 2'h0;
		return r;
	endfunction

	// operating mode table; unlisted codes come back invalid
	function automatic jmic_mode_s mode_lookup(input logic [4:0] code);
		jmic_mode_s r;
		r = '0;
		unique case (code)
			5'd0:    r = mk(6'd3,  1'b0, 5'd1,  1'b1, 2'd2, 5'd12, 5'd12, 4'd4, 4'd4, 4'd8, 4'd5, 5'd16);
			5'd1:    r = mk(6'd3,  1'b0, 5'd1,  1'b1, 2'd2, 5'd12, 5'd12, 4'd8, 4'd8, 4'd8, 4'd5, 5'd8);
			5'd2:    r = mk(6'd3,  1'b0, 5'd1,  1'b0, 2'd2, 5'd12, 5'd12, 4'd4, 4'd4, 4'd8, 4'd5, 5'd16);
			5'd3:    r = mk(6'd3,  1'b0, 5'd1,  1'b0, 2'd2, 5'd12, 5'd12, 4'd8, 4'd8, 4'd8, 4'd5, 5'd8);
			5'd4:    r = mk(6'd18, 1'b1, 5'd1,  1'b1, 2'd2, 5'd8,  5'd8,  4'd2, 4'd1, 4'd1, 4'd2, 5'd20);
			5'd5:    r = mk(6'd18, 1'b1, 5'd1,  1'b1, 2'd2, 5'd8,  5'd8,  4'd4, 4'd1, 4'd1, 4'd4, 5'd10);
			5'd6:    r = mk(6'd18, 1'b1, 5'd1,  1'b0, 2'd2, 5'd8,  5'd8,  4'd2, 4'd1, 4'd1, 4'd2, 5'd20);
			5'd7:    r = mk(6'd18, 1'b1, 5'd1,  1'b0, 2'd2, 5'd8,  5'd8,  4'd4, 4'd1, 4'd1, 4'd4, 5'd10);
			5'd9:    r = mk(6'd9,  1'b0, 5'd2,  1'b0, 2'd2, 5'd15, 5'd16, 4'd4, 4'd1, 4'd2, 4'd4, 5'd10);
			5'd10:   r = mk(6'd9,  1'b0, 5'd4,  1'b0, 2'd2, 5'd15, 5'd16, 4'd2, 4'd2, 4'd2, 4'd1, 5'd20);
			5'd11:   r = mk(6'd9,  1'b0, 5'd4,  1'b0, 2'd2, 5'd15, 5'd16, 4'd4, 4'd2, 4'd2, 4'd2, 5'd10);
			5'd12:   r = mk(6'd3,  1'b0, 5'd4,  1'b0, 2'd2, 5'd12, 5'd12, 4'd8, 4'd8, 4'd8, 4'd5, 5'd4);
			5'd13:   r = mk(6'd5,  1'b0, 5'd8,  1'b0, 2'd2, 5'd15, 5'd16, 4'd1, 4'd2, 4'd4, 4'd1, 5'd20);
			5'd14:   r = mk(6'd9,  1'b0, 5'd8,  1'b0, 2'd2, 5'd15, 5'd16, 4'd2, 4'd2, 4'd2, 4'd1, 5'd10);
			5'd15:   r = mk(6'd3,  1'b0, 5'd16, 1'b0, 2'd1, 5'd15, 5'd16, 4'd1, 4'd4, 4'd8, 4'd1, 5'd20);
			5'd16:   r = mk(6'd5,  1'b0, 5'd16, 1'b0, 2'd2, 5'd15, 5'd16, 4'd1, 4'd2, 4'd4, 4'd1, 5'd10);
			5'd17:   r = mk(6'd18, 1'b1, 5'd1,  1'b1, 2'd2, 5'd8,  5'd8,  4'd8, 4'd1, 4'd1, 4'd8, 5'd5);
			5'd18:   r = mk(6'd18, 1'b1, 5'd1,  1'b0, 2'd2, 5'd8,  5'd8,  4'd8, 4'd1, 4'd1, 4'd8, 5'd5);
			default: r = '0;
		endcase
		return r;
	endfunction

	// K legality for a mode: kmin <= K <= 32, K - kmin a multiple of the step
	function automatic logic k_legal(input jmic_mode_s md, input logic [4:0] k_m1);
		logic [5:0] k;
		logic [5:0] diff;
		k    = {1'b0, k_m1} + 6'h01;
		diff = k - md.kmin;
		return md.valid && (k >= md.kmin) && (k <= K_MAX) && !(md.kstep2 && diff[0]);
	endfunction
endpackage

// ===== src/jmic_lane.sv
// jmic_lane: per-lane identifier, lane enable and alignment-sequence checksum
`timescale 1ns/10ps
module jmic_lane #(
	parameter logic [4:0] LANE_ID = 5'h00
) (
	// link fields and lane usage
	input  wire jmic_pkg::jmic_link_s i_link,
	input  wire logic [3:0]           i_lanes_used,
	input  wire logic                 i_link_used,
	// lane results
	output logic [7:0]                o_chksum,
	output logic                      o_en
);
	// lowest lanes of a used link are on, the rest powered down
	assign o_en = i_link_used && ({1'b0, LANE_ID} < {2'b00, i_lanes_used});

	// sum of every other field, eight-bit wrap gives modulo 256
	always_comb begin
		o_chksum = i_link.did + 8'(i_link.bid) + 8'(i_link.adjcnt) + 8'(LANE_ID)
			+ 8'(i_link.phadj) + 8'(i_link.adjdir) + 8'(i_link.l_m1) + 8'(i_link.scr)
			+ i_link.f_m1 + 8'(i_link.k_m1) + i_link.m_m1 + 8'(i_link.cs) + 8'(i_link.n_m1)
			+ 8'(i_link.subclassv) + 8'(i_link.np_m1) + 8'(i_link.jesdv) + 8'(i_link.s_m1)
			+ 8'(i_link.hd) + 8'(i_link.cf) + i_link.res1 + i_link.res2;
	end
endmodule

// ===== verif/jmic_rx_model.sv
// jmic_rx_model: receiver side that recomputes the alignment checksum of one lane
`timescale 1ns/10ps
module jmic_rx_model (
	// alignment fields and lane id seen on the lane
	input  wire jmic_pkg::jmic_link_s i_link,
	input  wire logic [4:0]           i_lid,
	// checksum the receiver expects
	output logic [7:0]                o_sum
);
	// every format field enters one modulo-256 sum
	always_comb begin
		o_sum = i_link.did + 8'(i_link.bid) + 8'(i_link.adjcnt) + 8'(i_lid) + 8'(i_link.phadj)
			+ 8'(i_link.adjdir) + 8'(i_link.l_m1) + 8'(i_link.scr) + i_link.f_m1 + 8'(i_link.k_m1)
			+ i_link.m_m1 + 8'(i_link.cs) + 8'(i_link.n_m1) + 8'(i_link.subclassv) + 8'(i_link.np_m1)
			+ 8'(i_link.jesdv) + 8'(i_link.s_m1) + 8'(i_link.hd) + 8'(i_link.cf) + i_link.res1 + i_link.res2;
	end
endmodule

// ===== verif/jmic_assertions.sv
// jmic_checker: concurrent checks on the top ports of the mode/alignment block
`timescale 1ns/10ps
module jmic_checker (
	// clock, reset and bus handshake
	input  wire logic                 I_CORE_CLK,
	input  wire logic                 I_SYS_RST,
	input  wire logic                 I_WB_CYC,
	input  wire logic                 I_WB_STB,
	input  wire logic                 O_WB_ACK,
	// derived outputs
	input  wire logic                 O_INTERLEAVE,
	input  wire logic                 O_RATE_X2,
	input  wire logic                 O_INPUT_SEL,
	input  wire logic                 O_DDC_EN,
	input  wire logic [4:0]           O_DECIMATION,
	input  wire logic                 O_LINK_RST,
	input  wire logic [4:0]           O_PLL_MULT_X4,
	input  wire logic                 O_PLL_BYPASS,
	input  wire logic [15:0]          O_LANE_EN,
	input  wire jmic_pkg::jmic_link_s O_ILAS_A,
	input  wire jmic_pkg::jmic_link_s O_ILAS_B
);
	logic [1:0] cnt_ff;
	logic [1:0] nxt_cnt;
	logic       rdy;
	// derived outputs are left three edges after reset to settle
	always_comb begin
		nxt_cnt = I_SYS_RST ? 2'h0 : ((cnt_ff == 2'h3) ? cnt_ff : cnt_ff + 2'h1);
	end
	always_ff @(posedge I_CORE_CLK) begin
		cnt_ff <= nxt_cnt;
	end
	assign rdy = (cnt_ff == 2'h3);
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (I_SYS_RST || !rdy);
	a_ack_once: assert property ((I_WB_CYC && I_WB_STB && !O_WB_ACK) |=> O_WB_ACK ##1 !O_WB_ACK)
		else $error("ack not a single cycle after request");
	a_rate_twice: assert property (O_RATE_X2 == O_INTERLEAVE)
		else $error("rate flag differs from interleave");
	a_des_dec: assert property ($rose(O_INTERLEAVE) |-> O_DECIMATION == 5'h01)
		else $error("decimation in single-channel mode");
	a_input_dual: assert property (!O_INTERLEAVE |-> !O_INPUT_SEL)
		else $error("input select in dual mode");
	a_ddc_off: assert property (O_DDC_EN == (!O_INTERLEAVE && O_DECIMATION != 5'h01))
		else $error("down-conversion enable wrong");
	a_pll_bypass: assert property (O_PLL_BYPASS == (O_PLL_MULT_X4 == 5'h04))
		else $error("pll bypass wrong");
	a_zero_fields: assert property ((O_ILAS_A.adjcnt | O_ILAS_A.bid | O_ILAS_A.adjdir | O_ILAS_A.cf
		| O_ILAS_A.hd | O_ILAS_A.res1 | O_ILAS_A.res2 | O_ILAS_B.res1 | O_ILAS_B.res2) == 8'h00)
		else $error("fixed field not zero");
	a_cs_zero: assert property (O_ILAS_A.cs == 2'h0 && O_ILAS_B.cs == 2'h0)
		else $error("control bit field not zero");
	a_version_one: assert property (O_ILAS_A.jesdv == 3'h1 && O_ILAS_B.subclassv == 3'h1)
		else $error("version fields not one");
	a_did_next: assert property (O_ILAS_B.did == O_ILAS_A.did + 8'h01)
		else $error("second link identifier wrong");
	a_lanes_low: assert property ((((O_LANE_EN[7:0] + 8'h01) & O_LANE_EN[7:0])
		| ((O_LANE_EN[15:8] + 8'h01) & O_LANE_EN[15:8])) == 8'h00)
		else $error("used lanes not lowest");
	a_link_off: assert property (O_LINK_RST |-> O_LANE_EN == 16'h0000)
		else $error("lanes on while link disabled");
endmodule
bind jmic_top jmic_checker u_jmic_checker (.I_CORE_CLK, .I_SYS_RST, .I_WB_CYC, .I_WB_STB, .O_WB_ACK,
	.O_INTERLEAVE, .O_RATE_X2, .O_INPUT_SEL, .O_DDC_EN, .O_DECIMATION, .O_LINK_RST, .O_PLL_MULT_X4,
	.O_PLL_BYPASS, .O_LANE_EN, .O_ILAS_A, .O_ILAS_B);

// ===== verif/jmic_top_tb_top.sv
// jmic_top_tb_top: self-checking bench for the mode/alignment block
`timescale 1ns/10ps
module jmic_top_tb_top;
	logic                 clk, rst, cyc, stb, we, ack, ilv, x2, isel, ddc, lrst, scren, byp;
	logic [7:0]           adr, sum_a, sum_b;
	logic [3:0]           sel;
	logic [31:0]          wdat, rdat, rd;
	logic [4:0]           dec, pll;
	logic [15:0]          len;
	logic [127:0]         csum;
	logic [1:0]           csa;
	jmic_pkg::jmic_link_s ila, ilb;
	int                   errors = 0;
	int                   n_tests = 0;
	// expected mode table, index 8 unused
	int des_t[19] = '{1,1,0,0,1,1,0,0,0,0,0,0,0,0,0,0,0,1,0};
	int dec_t[19] = '{1,1,1,1,1,1,1,1,0,2,4,4,4,8,8,16,16,1,1};
	int rx_t[19]  = '{16,8,16,8,20,10,20,10,0,10,20,10,4,20,10,20,10,5,5};
	int l_t[19]   = '{4,8,4,8,2,4,2,4,0,4,2,4,8,1,2,1,1,8,8};
	int m_t[19]   = '{4,8,4,8,1,1,1,1,0,1,2,2,8,2,2,4,2,1,1};
	int f_t[19]   = '{8,8,8,8,1,1,1,1,0,2,2,2,8,4,2,8,4,1,1};
	int s_t[19]   = '{5,5,5,5,2,4,2,4,0,4,1,2,5,1,1,1,1,8,8};
	jmic_top u_jmic_top (.I_CORE_CLK(clk), .I_SYS_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
		.I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .O_INTERLEAVE(ilv),
		.O_RATE_X2(x2), .O_INPUT_SEL(isel), .O_DDC_EN(ddc), .O_DECIMATION(dec), .O_LINK_RST(lrst),
		.O_SCR_EN(scren), .O_PLL_MULT_X4(pll), .O_PLL_BYPASS(byp), .O_LANE_EN(len), .O_ILAS_A(ila),
		.O_ILAS_B(ilb), .O_LANE_CHKSUM(csum), .O_CS_ACTUAL(csa));
	// receiver view of lane 0 of link A and lane 1 of link B
	jmic_rx_model u_jmic_rx_model (.i_link(ila), .i_lid(5'h00), .o_sum(sum_a));
	jmic_rx_model u_jmic_rx_model_b (.i_link(ilb), .i_lid(5'h01), .o_sum(sum_b));
	// free-running core clock
	always #25 clk = ~clk;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("ERROR %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// one classic bus cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		do begin
			@(posedge clk);
			t++;
		end while (ack !== 1'b1 && t < 50);
		if (ack !== 1'b1) begin
			errors++;
			$display("ERROR %0t: bus cycle not answered", $time);
		end
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic t_reset;
		wb(1'b0, jmic_pkg::ADR_CTRL, 32'h0);
		chk(rd, 32'h0);
		wb(1'b0, jmic_pkg::ADR_MODE, 32'h0);
		chk(rd, 32'h0);
		wb(1'b0, jmic_pkg::ADR_K_M1, 32'h0);
		chk(rd, 32'h1F);
		wb(1'b0, jmic_pkg::ADR_DID, 32'h0);
		chk(rd, 32'h0);
		wb(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		chk(32'({lrst, len}), 32'h10000);
		$display("reset test done");
	endtask
	task automatic t_modes;
		int ln;
		int nn;
		for (int i = 0; i < 19; i++) begin
			if (i == 8) continue;
			wb(1'b1, jmic_pkg::ADR_CTRL, 32'h0);
			wb(1'b1, jmic_pkg::ADR_MODE, 32'(i));
			wb(1'b1, jmic_pkg::ADR_CTRL, 32'h1);
			settle();
			ln = (1 << l_t[i]) - 1;
			nn = (i < 4 || i == 12) ? 12 : ((i < 8 || i > 16) ? 8 : 15);
			chk(32'(ilv), 32'(des_t[i]));
			chk(32'(x2), 32'(des_t[i]));
			chk(32'(dec), 32'(dec_t[i]));
			chk(32'(pll), 32'(rx_t[i]));
			chk(32'(byp), 32'(rx_t[i] == 4));
			chk(32'(ddc), 32'(des_t[i] == 0 && dec_t[i] > 1));
			chk(32'(len), 32'((i == 15 ? 0 : ln << 8) | ln));
			chk(32'({ila.l_m1, ila.f_m1, ila.m_m1, ila.s_m1}), 32'({5'(l_t[i] - 1), 8'(f_t[i] - 1),
				8'(m_t[i] - 1), 5'(s_t[i] - 1)}));
			chk(32'({ila.n_m1, ila.np_m1}), 32'({5'(nn - 1), 5'((nn == 15 ? 16 : nn) - 1)}));
			chk(32'({csa, ila.cs}), 32'({2'(i > 8 && i < 17 && i != 12), 2'h0}));
			chk(32'({csum[7:0], csum[79:72]}), 32'({sum_a, sum_b}));
			wb(1'b0, jmic_pkg::ADR_STATUS, 32'h0);
			chk(32'(rd[0]), 32'(des_t[i]));
		end
		wb(1'b1, jmic_pkg::ADR_CTRL, 32'h0);
		$display("mode test done");
	endtask
	task automatic t_bad_mode;
		wb(1'b1, jmic_pkg::ADR_MODE, 32'h8);
		wb(1'b1, jmic_pkg::ADR_MODE, 32'h13);
		wb(1'b1, jmic_pkg::ADR_MODE, 32'h1F);
		wb(1'b0, jmic_pkg::ADR_MODE, 32'h0);
		chk(rd, 32'h12);
		$display("undefined mode test done");
	endtask
	task automatic t_kmult;
		wb(1'b1, jmic_pkg::ADR_MODE, 32'h4);
		wb(1'b1, jmic_pkg::ADR_K_M1, 32'h11);
		wb(1'b1, jmic_pkg::ADR_K_M1, 32'h12);
		wb(1'b1, jmic_pkg::ADR_K_M1, 32'h10);
		settle();
		chk(32'(ila.k_m1), 32'h11);
		wb(1'b0, jmic_pkg::ADR_K_M1, 32'h0);
		chk(rd, 32'h11);
		wb(1'b1, jmic_pkg::ADR_MODE, 32'h0);
		wb(1'b1, jmic_pkg::ADR_K_M1, 32'h2);
		wb(1'b1, jmic_pkg::ADR_K_M1, 32'h1);
		wb(1'b0, jmic_pkg::ADR_K_M1, 32'h0);
		chk(rd, 32'h2);
		wb(1'b1, jmic_pkg::ADR_MODE, 32'h4);
		wb(1'b0, jmic_pkg::ADR_STATUS, 32'h0);
		chk(32'(rd[1]), 32'h0);
		wb(1'b1, jmic_pkg::ADR_MODE, 32'h0);
		wb(1'b1, jmic_pkg::ADR_K_M1, 32'h1F);
		$display("multiframe test done");
	endtask
	task automatic t_user;
		wb(1'b1, jmic_pkg::ADR_DID, 32'hFF);
		wb(1'b1, jmic_pkg::ADR_CTRL, 32'h7);
		settle();
		chk(32'({ila.did, ilb.did}), 32'hFF00);
		chk(32'({scren, ila.scr, isel, lrst}), 32'hE);
		wb(1'b0, jmic_pkg::ADR_CHKSUM, 32'h0);
		chk(32'(rd[7:0]), 32'(sum_a));
		wb(1'b1, jmic_pkg::ADR_CTRL, 32'h6);
		wb(1'b1, jmic_pkg::ADR_MODE, 32'h2);
		wb(1'b1, jmic_pkg::ADR_CTRL, 32'h7);
		settle();
		chk(32'(isel), 32'h0);
		wb(1'b1, jmic_pkg::ADR_CTRL, 32'h0);
		settle();
		chk(32'({lrst, len}), 32'h10000);
		$display("user field test done");
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// main sequence
	initial begin
		{clk, rst, cyc, stb, we, adr, sel, wdat} = {2'b01, 3'b000, 8'h00, 4'h0, 32'h0};
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_modes();
		t_bad_mode();
		t_kmult();
		t_user();
		finish_test();
	end
	// watchdog against a hung bus cycle
	initial begin
		#1000000;
		errors++;
		$display("ERROR %0t: watchdog expired", $time);
		finish_test();
	end
endmodule
